// file: common/pwr_link_if.sv
// interface: pins between host and module power-control logic
// assumes both ends share core_clk; open-drain key is modelled as a plain level
`timescale 1ns/1ps
interface pwr_link_if;
  logic powerKeyN;    // power_key_n, active low
  logic resetLineN;   // module reset, active low
  logic ringWakeOut;  // ring_wake_out, wake square wave
  logic statusRun;    // running-status indication
  logic vbatOk;       // supply good

  modport device (input powerKeyN, input resetLineN, input vbatOk,
                  output ringWakeOut, output statusRun);
  modport host   (output powerKeyN, output resetLineN, output vbatOk,
                  input ringWakeOut, input statusRun);
endinterface

// file: common/pwr_seq_pkg.sv
// package: timing constants and state types for the power-key / reset / ring link
// assumes one core clock at 125 MHz; all long times are counted in milliseconds
package pwr_seq_pkg;

  // ----------------------------------------------------------------
  // clock and millisecond tick
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 8;
  localparam int NS_PER_MS      = 1000000;
  localparam int CYC_PER_MS     = NS_PER_MS / CLK_PERIOD_NS;
  localparam int TICK_W         = 17;

  // ----------------------------------------------------------------
  // times in milliseconds (or seconds where printed so)
  // ----------------------------------------------------------------
  localparam int KEY_ON_MIN_MS  = 100;
  localparam int KEY_ON_TYP_MS  = 500;
  localparam int STATUS_MIN_MS  = 22;
  localparam int USB_UP_S       = 10;
  localparam int UART_UP_S      = 6;
  localparam int MS_PER_S       = 1000;
  localparam int KEY_OFF_MIN_S  = 1;
  localparam int RST_MIN_MS     = 150;
  localparam int RST_TYP_MS     = 200;
  localparam int RST_MAX_MS     = 450;
  localparam int RING_PERIOD_MS = 500;
  localparam int RING_HALF_MS   = 250;
  localparam int SHUTDOWN_MS    = 50;

  localparam int USB_UP_MS      = USB_UP_S * MS_PER_S;
  localparam int UART_UP_MS     = UART_UP_S * MS_PER_S;
  localparam int KEY_OFF_MIN_MS = KEY_OFF_MIN_S * MS_PER_S;

  localparam int MS_W           = 14;

  typedef enum {DEV_OFF, DEV_BOOT, DEV_RUN, DEV_SHUTDOWN} dev_state_t;
  typedef enum {HOST_IDLE, HOST_KEY_LOW, HOST_RST_LOW} host_state_t;

endpackage

// file: hw/pwr_seq_device.sv
// module end: boot, orderly shutdown, reset and ring-wake generation
// assumes link pins are synchronous to core_clk and the host keeps its pulse widths
`timescale 1ns/1ps
module pwr_seq_device
  import pwr_seq_pkg::*;
#(
  parameter int CYC_PER_TICK = CYC_PER_MS   // core cycles per ms tick
)
(
  input  wire logic core_clk,       // 125 MHz clock
  input  wire logic reset_n,        // async reset, active low
  pwr_link_if.device link,          // pins toward host
  input  wire logic ringEvent,      // one-cycle pulse: message or call arrived
  input  wire logic ringStop,       // one-cycle pulse: ring cleared
  output logic      running,        // module running
  output logic      usbReady,       // usb port usable
  output logic      uartReady,      // main serial port usable
  output logic      inShutdown      // orderly shutdown in progress
);

  // ----------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tickCnt_ff;
  wire               msTick = (tickCnt_ff == TICK_W'(CYC_PER_TICK - 1));

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      tickCnt_ff <= '0;
    else
      tickCnt_ff <= msTick ? '0 : tickCnt_ff + 1'b1;

  function automatic logic [MS_W-1:0] msInc(input logic [MS_W-1:0] v);
    msInc = (&v) ? v : v + 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // pulse width measurement
  // ----------------------------------------------------------------
  logic [MS_W-1:0] keyMs_ff;
  logic [MS_W-1:0] rstMs_ff;
  logic            keyPrev_ff;
  logic            rstPrev_ff;

  wire keyLow      = !link.powerKeyN;
  wire rstLow      = !link.resetLineN;
  wire keyRelease  = keyPrev_ff && !keyLow;
  wire rstRelease  = rstPrev_ff && !rstLow;

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      keyMs_ff <= '0;
    else if (!keyLow)
      keyMs_ff <= '0;
    else if (msTick)
      keyMs_ff <= msInc(keyMs_ff);

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      rstMs_ff <= '0;
    else if (!rstLow)
      rstMs_ff <= '0;
    else if (msTick)
      rstMs_ff <= msInc(rstMs_ff);

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      keyPrev_ff <= 1'b0;
      rstPrev_ff <= 1'b0;
    end
    else
    begin
      keyPrev_ff <= keyLow;
      rstPrev_ff <= rstLow;
    end

  wire startValid = keyRelease && (keyMs_ff >= MS_W'(KEY_ON_MIN_MS));
  wire stopValid  = keyRelease && (keyMs_ff >= MS_W'(KEY_OFF_MIN_MS));
  // reset accepted only at or above the minimum width; no upper limit is checked
  wire rstValid   = rstRelease && (rstMs_ff >= MS_W'(RST_MIN_MS));

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  dev_state_t      state_ff;
  dev_state_t      nxt_state;
  logic [MS_W-1:0] phaseMs_ff;
  logic [MS_W-1:0] nxt_phaseMs;

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_phaseMs = msTick ? msInc(phaseMs_ff) : phaseMs_ff;
    case (state_ff)
      DEV_OFF:
        if (startValid)
        begin
          nxt_state   = DEV_BOOT;
          nxt_phaseMs = '0;
        end
      DEV_BOOT:
        // hold status back 22ms
        // free-running tick: one spare tick keeps it past 22ms
        if (phaseMs_ff > MS_W'(STATUS_MIN_MS))
          nxt_state = DEV_RUN;
      DEV_RUN:
        if (stopValid)
        begin
          nxt_state   = DEV_SHUTDOWN;
          nxt_phaseMs = '0;
        end
        // reset restarts the boot sequence
        else if (rstValid)
        begin
          nxt_state   = DEV_BOOT;
          nxt_phaseMs = '0;
        end
      DEV_SHUTDOWN:
        if (phaseMs_ff >= MS_W'(SHUTDOWN_MS))
          nxt_state = DEV_OFF;
      default:
        nxt_state = DEV_OFF;
    endcase
    if (!link.vbatOk)
    begin
      nxt_state   = DEV_OFF;
      nxt_phaseMs = '0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      state_ff   <= DEV_OFF;
      phaseMs_ff <= '0;
    end
    else
    begin
      state_ff   <= nxt_state;
      phaseMs_ff <= nxt_phaseMs;
    end

  // ----------------------------------------------------------------
  // port readiness, timed from entry to boot after the start or reset pulse
  // ----------------------------------------------------------------
  logic [MS_W-1:0] upMs_ff;
  wire             isUp = (state_ff == DEV_BOOT) || (state_ff == DEV_RUN);

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      upMs_ff <= '0;
    else if (!isUp || (nxt_state == DEV_BOOT && state_ff != DEV_BOOT))
      upMs_ff <= '0;
    else if (msTick)
      upMs_ff <= msInc(upMs_ff);

  wire usbUp  = (state_ff == DEV_RUN) && (upMs_ff >= MS_W'(USB_UP_MS));
  wire uartUp = (state_ff == DEV_RUN) && (upMs_ff >= MS_W'(UART_UP_MS));

  // ----------------------------------------------------------------
  // ring indicator
  // ----------------------------------------------------------------
  logic            ringOn_ff;
  logic            ringLevel_ff;
  logic [MS_W-1:0] ringMs_ff;

  wire ringHalfDone = msTick && (ringMs_ff == MS_W'(RING_HALF_MS - 1));

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      ringOn_ff    <= 1'b0;
      ringLevel_ff <= 1'b0;
      ringMs_ff    <= '0;
    end
    else if (state_ff != DEV_RUN || (ringStop && !ringEvent))
    begin
      ringOn_ff    <= 1'b0;
      ringLevel_ff <= 1'b0;
      ringMs_ff    <= '0;
    end
    else if (ringEvent && !ringOn_ff)
    begin
      ringOn_ff    <= 1'b1;
      ringLevel_ff <= 1'b1;
      ringMs_ff    <= '0;
    end
    else if (ringOn_ff && ringHalfDone)
    begin
      ringLevel_ff <= !ringLevel_ff;
      ringMs_ff    <= '0;
    end
    else if (ringOn_ff && msTick)
      ringMs_ff <= ringMs_ff + 1'b1;

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  logic statusRun_ff;
  logic ringOut_ff;

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      statusRun_ff <= 1'b0;
      ringOut_ff   <= 1'b0;
      running      <= 1'b0;
      usbReady     <= 1'b0;
      uartReady    <= 1'b0;
      inShutdown   <= 1'b0;
    end
    else
    begin
      statusRun_ff <= (state_ff == DEV_RUN);
      ringOut_ff   <= ringOn_ff && ringLevel_ff;
      running      <= (state_ff == DEV_RUN);
      usbReady     <= usbUp;
      uartReady    <= uartUp;
      inShutdown   <= (state_ff == DEV_SHUTDOWN);
    end

  assign link.statusRun   = statusRun_ff;
  assign link.ringWakeOut = ringOut_ff;

endmodule // pwr_seq_device

// file: hw/pwr_seq_host.sv
// host end: drives power key and reset pulses of legal width, watches ring
// assumes the module end shares core_clk through pwr_link_if
`timescale 1ns/1ps
module pwr_seq_host
  import pwr_seq_pkg::*;
#(
  parameter int CYC_PER_TICK = CYC_PER_MS  // core cycles per ms tick
)
(
  input  wire logic core_clk,      // 125 MHz clock
  input  wire logic reset_n,       // async reset, active low
  pwr_link_if.host  link,          // pins toward module
  input  wire logic startReq,      // one-cycle pulse: power the module on
  input  wire logic stopReq,       // one-cycle pulse: orderly shutdown
  input  wire logic resetReq,      // one-cycle pulse: reset hung module
  input  wire logic supplyOn,      // supply switch level
  output logic      busy,          // pulse in progress
  output logic      modRunning,    // status seen from module
  output logic      ringSeen       // ring line level
);

  // ----------------------------------------------------------------
  // millisecond tick and pulse timer
  // ----------------------------------------------------------------
  logic [TICK_W-1:0] tickCnt_ff;
  wire               msTick = (tickCnt_ff == TICK_W'(CYC_PER_TICK - 1));

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      tickCnt_ff <= '0;
    else
      tickCnt_ff <= msTick ? '0 : tickCnt_ff + 1'b1;

  host_state_t     state_ff;
  host_state_t     nxt_state;
  logic [MS_W-1:0] ms_ff;
  logic [MS_W-1:0] nxt_ms;
  logic [MS_W-1:0] target_ff;
  logic [MS_W-1:0] nxt_target;

  // one spare tick: the free tick phase would cut the hold short
  wire done = msTick && (ms_ff >= target_ff);

  always_comb
  begin
    nxt_state  = state_ff;
    nxt_target = target_ff;
    nxt_ms     = msTick ? ms_ff + 1'b1 : ms_ff;
    case (state_ff)
      HOST_IDLE:
      begin
        nxt_ms = '0;
        if (startReq)
        begin
          nxt_state  = HOST_KEY_LOW;
          nxt_target = MS_W'(KEY_ON_TYP_MS);
        end
        // shut down by key, not supply
        else if (stopReq)
        begin
          nxt_state  = HOST_KEY_LOW;
          nxt_target = MS_W'(KEY_OFF_MIN_MS);
        end
        else if (resetReq)
        begin
          nxt_state  = HOST_RST_LOW;
          nxt_target = MS_W'(RST_TYP_MS);
        end
      end
      HOST_KEY_LOW, HOST_RST_LOW:
        if (done)
          nxt_state = HOST_IDLE;
      default:
        nxt_state = HOST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      state_ff  <= HOST_IDLE;
      ms_ff     <= '0;
      target_ff <= '0;
    end
    else
    begin
      state_ff  <= nxt_state;
      ms_ff     <= nxt_ms;
      target_ff <= nxt_target;
    end

  // ----------------------------------------------------------------
  // registered pins and status
  // ----------------------------------------------------------------
  logic keyN_ff;
  logic rstN_ff;
  logic vbat_ff;

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      keyN_ff    <= 1'b1;
      rstN_ff    <= 1'b1;
      vbat_ff    <= 1'b0;
      busy       <= 1'b0;
      modRunning <= 1'b0;
      ringSeen   <= 1'b0;
    end
    else
    begin
      keyN_ff    <= (nxt_state != HOST_KEY_LOW);
      rstN_ff    <= (nxt_state != HOST_RST_LOW);
      vbat_ff    <= supplyOn;
      busy       <= (nxt_state != HOST_IDLE);
      modRunning <= link.statusRun;
      ringSeen   <= link.ringWakeOut;
    end

  assign link.powerKeyN  = keyN_ff;
  assign link.resetLineN = rstN_ff;
  assign link.vbatOk     = vbat_ff;

endmodule // pwr_seq_host

// file: testbench/pwr_link_asserts.sv
// checker: timing relations on the host/module power link
// assumes both ends share core_clk and reset_n
`timescale 1ns/1ps
module pwr_link_asserts
  import pwr_seq_pkg::*;
#(
  parameter int CYC_PER_TICK = CYC_PER_MS  // core cycles per ms tick
)
(
  input wire logic core_clk,    // clock
  input wire logic reset_n,     // async reset, low
  input wire logic powerKeyN,   // key, low active
  input wire logic resetLineN,  // module reset, low active
  input wire logic ringWakeOut, // ring wave
  input wire logic statusRun,   // running status
  input wire logic vbatOk       // supply good
);
  localparam int MS = CYC_PER_TICK;
  logic [31:0] keyCnt_ff;
  logic [31:0] keyLast_ff;
  logic [31:0] rstCnt_ff;
  logic [31:0] relCnt_ff;
  logic [31:0] ringCnt_ff;
  // ----------------------------------------
  // pulse width counters
  // ----------------------------------------
  // 32 bits: widest span is about 1 s of cycles
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      keyCnt_ff  <= 32'h0;
      keyLast_ff <= 32'h0;
      rstCnt_ff  <= 32'h0;
      relCnt_ff  <= 32'h0;
      ringCnt_ff <= 32'h0;
    end
    else
    begin
      keyCnt_ff  <= powerKeyN ? 32'h0 : keyCnt_ff + 32'h1;
      keyLast_ff <= (powerKeyN && keyCnt_ff != 32'h0) ? keyCnt_ff : keyLast_ff;
      rstCnt_ff  <= resetLineN ? 32'h0 : rstCnt_ff + 32'h1;
      relCnt_ff  <= (!powerKeyN || !resetLineN) ? 32'h0 : relCnt_ff + 32'h1;
      ringCnt_ff <= ringWakeOut ? ringCnt_ff + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_key_min_width: assert property (
    $rose(powerKeyN) |-> keyCnt_ff >= KEY_ON_MIN_MS * MS)
    else $error("key pulse shorter than start minimum");
  a_status_not_early: assert property (
    $rose(statusRun) |-> relCnt_ff >= STATUS_MIN_MS * MS)
    else $error("status rose too soon after release");
  a_short_key_ignored: assert property (
    $rose(statusRun) |-> keyLast_ff >= (KEY_ON_MIN_MS - 1) * MS)
    else $error("status rose after a short key pulse");
  a_key_max_width: assert property (keyCnt_ff <= (KEY_OFF_MIN_MS + 1) * MS)
    else $error("key held low beyond shutdown width");
  a_reset_width: assert property (
    $rose(resetLineN) |-> rstCnt_ff >= RST_MIN_MS * MS && rstCnt_ff <= RST_MAX_MS * MS)
    else $error("reset pulse width out of range");
  a_single_pulse: assert property (!(!powerKeyN && !resetLineN))
    else $error("key and reset low together");
  a_ring_idle_low: assert property ((!statusRun)[*3] |-> !ringWakeOut)
    else $error("ring high while module not running");
  a_ring_half_len: assert property (ringCnt_ff <= (RING_HALF_MS + 1) * MS)
    else $error("ring high phase too long");
  // ring output trails the state by two registers
  a_supply_cut: assert property (!vbatOk |-> ##[0:3] (!statusRun && !ringWakeOut))
    else $error("module still active without supply");
endmodule // pwr_link_asserts

// file: testbench/tb_top.sv
// testbench: host end and module end joined over the power link
// assumes package and interface compiled first; ms tick shortened by parameter
`timescale 1ns/1ps
module tb_top
  import pwr_seq_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ringEvent = 1'b0;
  logic ringStop = 1'b0;
  logic startReq = 1'b0;
  logic stopReq = 1'b0;
  logic resetReq = 1'b0;
  logic supplyOn = 1'b0;
  logic running, usbReady, uartReady, inShutdown, busy, modRunning, ringSeen;
  int   failures = 0;
  int   checks = 0;
  // ms shortened to a few cycles so second-long spans fit the run
  localparam int TICK       = 4;
  localparam int IDLE_LIMIT = (KEY_OFF_MIN_MS + 2) * TICK + 8;
  pwr_link_if link();
  always #4 core_clk = ~core_clk;
  pwr_seq_device #(.CYC_PER_TICK(TICK)) i_pwr_seq_device (.core_clk(core_clk),
    .reset_n(reset_n), .link(link.device),
    .ringEvent(ringEvent), .ringStop(ringStop), .running(running), .usbReady(usbReady),
    .uartReady(uartReady), .inShutdown(inShutdown));
  pwr_seq_host #(.CYC_PER_TICK(TICK)) i_pwr_seq_host (.core_clk(core_clk),
    .reset_n(reset_n), .link(link.host),
    .startReq(startReq), .stopReq(stopReq), .resetReq(resetReq), .supplyOn(supplyOn),
    .busy(busy), .modRunning(modRunning), .ringSeen(ringSeen));
  pwr_link_asserts #(.CYC_PER_TICK(TICK)) i_pwr_link_asserts (.core_clk(core_clk),
    .reset_n(reset_n),
    .powerKeyN(link.powerKeyN), .resetLineN(link.resetLineN), .ringWakeOut(link.ringWakeOut),
    .statusRun(link.statusRun), .vbatOk(link.vbatOk));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // inputs move 1 ns after the edge, clear of sampling
  task automatic step(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic pulse(input int which);
    startReq = (which == 0);
    stopReq = (which == 1);
    resetReq = (which == 2);
    step();
    startReq = 1'b0;
    stopReq = 1'b0;
    resetReq = 1'b0;
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    step(2);
    reset_n = 1'b1;
    step();
  endtask
  task automatic ring_kick();
    ringEvent = 1'b1;
    step();
    ringEvent = 1'b0;
  endtask
  task automatic ring_stop();
    ringStop = 1'b1;
    step();
    ringStop = 1'b0;
  endtask
  // busy falls on the edge that releases the pin
  task automatic wait_idle();
    for (int n = 0; n < IDLE_LIMIT && busy; n++)
      step();
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    do_reset();
    check("powerKeyN", 1'b1, link.powerKeyN);
    check("resetLineN", 1'b1, link.resetLineN);
    check("ringWakeOut", 1'b0, link.ringWakeOut);
    check("statusRun", 1'b0, link.statusRun);
    check("busy", 1'b0, busy);
    supplyOn = 1'b1;
    check("vbatOk early", 1'b0, link.vbatOk);
    step();
    check("vbatOk", 1'b1, link.vbatOk);
    $display("test reset_values done");
  endtask
  // second request while busy must leave the other pin alone
  task automatic t_requests();
    for (int i = 0; i < 3; i++)
    begin
      do_reset();
      supplyOn = 1'b1;
      step(2);
      pulse(i);
      step();
      check("powerKeyN low", i == 2, link.powerKeyN);
      check("resetLineN low", i != 2, link.resetLineN);
      check("busy", 1'b1, busy);
      pulse(i == 2 ? 0 : 2);
      ring_kick();
      step(100);
      check("powerKeyN held", i == 2, link.powerKeyN);
      check("resetLineN held", i != 2, link.resetLineN);
      check("ring idle", 1'b0, link.ringWakeOut);
      check("ringSeen", 1'b0, ringSeen);
      check("running", 1'b0, running);
      check("modRunning", 1'b0, modRunning);
      check("uartReady", 1'b0, uartReady);
      check("usbReady", 1'b0, usbReady);
    end
    $display("test requests done");
  endtask
  task automatic t_supply_loss();
    do_reset();
    supplyOn = 1'b1;
    step(2);
    pulse(0);
    wait_idle();
    step(24 * TICK + 4);
    check("running", 1'b1, running);
    ring_kick();
    step();
    check("ring on", 1'b1, link.ringWakeOut);
    supplyOn = 1'b0;
    step(4);
    check("vbatOk", 1'b0, link.vbatOk);
    check("statusRun", 1'b0, link.statusRun);
    check("running off", 1'b0, running);
    check("inShutdown", 1'b0, inShutdown);
    check("ring", 1'b0, link.ringWakeOut);
    $display("test supply_loss done");
  endtask
  // key pulse cut short by reset_n in mid-pulse, before the module runs
  task automatic t_cut_pulse();
    do_reset();
    supplyOn = 1'b1;
    step(2);
    pulse(0);
    step(100);
    reset_n = 1'b0;
    step();
    check("key released", 1'b1, link.powerKeyN);
    check("busy", 1'b0, busy);
    reset_n = 1'b1;
    step(200);
    check("running", 1'b0, running);
    check("inShutdown", 1'b0, inShutdown);
    check("statusRun", 1'b0, link.statusRun);
    $display("test cut_pulse done");
  endtask
  // start, status, port readiness, ring wave, orderly shutdown
  task automatic t_power_cycle();
    do_reset();
    supplyOn = 1'b1;
    step(2);
    pulse(0);
    wait_idle();
    check("start released", 1'b1, link.powerKeyN);
    step(22 * TICK + 2);
    check("status early", 1'b0, link.statusRun);
    step(TICK + 2);
    check("status", 1'b1, link.statusRun);
    check("modRunning", 1'b1, modRunning);
    step((UART_UP_MS - 24) * TICK - 4);
    check("uart early", 1'b0, uartReady);
    step(2 * TICK);
    check("uartReady", 1'b1, uartReady);
    step((USB_UP_MS - UART_UP_MS - 2) * TICK);
    check("usb early", 1'b0, usbReady);
    step(2 * TICK);
    check("usbReady", 1'b1, usbReady);
    ring_kick();
    step();
    check("ring high", 1'b1, link.ringWakeOut);
    step((RING_HALF_MS - 10) * TICK);
    check("ring still high", 1'b1, link.ringWakeOut);
    check("ringSeen", 1'b1, ringSeen);
    step(20 * TICK);
    check("ring low", 1'b0, link.ringWakeOut);
    step((RING_HALF_MS - 30) * TICK);
    check("ring still low", 1'b0, link.ringWakeOut);
    step(40 * TICK);
    check("ring high again", 1'b1, link.ringWakeOut);
    ring_stop();
    step();
    check("ring stopped", 1'b0, link.ringWakeOut);
    pulse(1);
    wait_idle();
    check("stop released", 1'b1, link.powerKeyN);
    step(2);
    check("inShutdown", 1'b1, inShutdown);
    check("running off", 1'b0, running);
    check("usb off", 1'b0, usbReady);
    step((SHUTDOWN_MS + 2) * TICK);
    check("shutdown over", 1'b0, inShutdown);
    check("status off", 1'b0, link.statusRun);
    $display("test power_cycle done");
  endtask
  // reset pulse while running restarts the boot
  task automatic t_reboot();
    do_reset();
    supplyOn = 1'b1;
    step(2);
    pulse(0);
    wait_idle();
    step(24 * TICK + 4);
    check("running", 1'b1, running);
    pulse(2);
    check("resetLineN low", 1'b0, link.resetLineN);
    wait_idle();
    check("reset released", 1'b1, link.resetLineN);
    step(2);
    check("rebooting", 1'b0, running);
    step(24 * TICK + 4);
    check("running again", 1'b1, running);
    $display("test reboot done");
  endtask
  initial
  begin
    t_reset_values();
    t_requests();
    t_supply_loss();
    t_cut_pulse();
    t_power_cycle();
    t_reboot();
    complete_run();
  end
  // planned run is about 54000 cycles
  initial
  begin
    #(CLK_PERIOD_NS * 80000);
    failures++;
    $display("MISMATCH watchdog expected done seen timeout");
    complete_run();
  end
endmodule // tb_top
